// ---- hdl/plc_clk_net.sv ----
// One global clock network: pin select, polarity, rising-edge pulse
`timescale 1ns/1ps
module plc_clk_net (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pin_a,
  input  wire logic pin_b,
  input  wire logic pin_sel,
  input  wire logic invert,
  output logic      edge_pulse
);

  logic level;
  logic level_d;

  assign level = (pin_sel ? pin_b : pin_a) ^ invert;

  // Held high in reset so an inverted idle pin makes no false edge
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      level_d    <= 1'b1;
      edge_pulse <= 1'b0;
    end else begin
      level_d    <= level;
      edge_pulse <= level & ~level_d;
    end
  end

endmodule : plc_clk_net

// ---- hdl/plc_macrocell_group.sv ----
// Macrocell group: term array, expanders, programmable flip-flops, pin outputs
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// [R1] Each macrocell is set on its own to be registered or purely combinatorial.
// [R2] The flip-flop clocks by global clock, gated global clock or a product-term clock.
// [R3] In gated mode the flip-flop loads only on global edges where its enable term is high.
// [R4] In array mode the clock is a product term fed by feedback or pin signals.
// [R5] Two global networks each pick true or inverted of either global clock pin.
// [R6] Preset and clear are each a product term, acting when that term is high.
// [R7] Per macrocell, the low global clear pin may also clear the flip-flop.
// [R8] Every flip-flop starts at zero after power-up, before any clock.
// [R9] A pin can feed a flip-flop data input directly, bypassing array and logic.
// [R10] Each macrocell owns five product terms ORed into its function.
// [R11] Shareable and parallel expander terms add terms to any macrocell of the group; macrocell 0 has no parallel expander here.
// [R12] The group takes 36 interconnect inputs plus the global control signals.
// [R13] A low-power setting adds delay per macrocell without changing the function.
// [R14] A pin may act as open drain, driving only low or releasing.
// [R15] With preset and clear both active, the flip-flop goes to zero.
module plc_macrocell_group (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [12:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        global_clock_pin_a,
  input  wire logic        global_clock_pin_b,
  input  wire logic        global_clear_pin_low,
  input  wire logic [35:0] global_interconnect_array,
  input  wire logic [15:0] io_pin_in,
  output logic      [15:0] io_pin_out,
  output logic      [15:0] io_pin_oe,
  output logic      [15:0] mc_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [plc_pkg::NUM_LIT-1:0]  pt_true [plc_pkg::NUM_TERM];
  logic [plc_pkg::NUM_LIT-1:0]  pt_comp [plc_pkg::NUM_TERM];
  logic [31:0]                  mc_cfg  [plc_pkg::NUM_MC];
  logic [3:0]                   gcfg;

  logic [plc_pkg::SYNC_W-1:0]   sync_in;
  logic [plc_pkg::SYNC_W-1:0]   sync_q;
  logic [35:0]                  gia_s;
  logic [15:0]                  io_s;
  logic                         clk_a_s;
  logic                         clk_b_s;
  logic                         gclr_low_s;
  logic [1:0]                   net_pulse;

  logic [15:0]                  mc_q;
  logic [plc_pkg::NUM_LIT-1:0]  lits;
  logic [plc_pkg::NUM_TERM-1:0] term_hit;
  logic [15:0]                  own_sum;
  logic [16:0]                  own_chain;
  logic [15:0]                  shx;
  logic [15:0]                  logic_sum;
  logic [15:0]                  lp_dly;
  logic [15:0]                  data_in;
  logic [15:0]                  clk_term;
  logic [15:0]                  aclk_d;
  logic [15:0]                  clk_ev;
  logic [15:0]                  do_preset;
  logic [15:0]                  do_clear;

  logic                         wr_go;
  logic                         rd_go;
  logic [7:0]                   term_idx;
  logic [1:0]                   term_word;
  logic [3:0]                   cfg_idx;
  logic                         in_term;
  logic                         in_cfg;
  logic [31:0]                  next_readdata;

  // Slots are laid out the same way in every macrocell
  function automatic int slot(input int mc, input int s);
    slot = mc * plc_pkg::SLOT_PER_MC + s;
  endfunction : slot

  // ----------------------------------------------------------------
  // Pin synchronisers and clock networks
  // ----------------------------------------------------------------
  // Clock and clear pins share the two-flop path of the data pins
  assign sync_in = {global_clear_pin_low, global_clock_pin_b, global_clock_pin_a,
                    io_pin_in, global_interconnect_array};

  plc_sync #(
    .W (plc_pkg::SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  assign gia_s      = sync_q[35:0];  // R12
  assign io_s       = sync_q[51:36];
  assign clk_a_s    = sync_q[52];
  assign clk_b_s    = sync_q[53];
  assign gclr_low_s = sync_q[54];

  plc_clk_net u_net0 (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .pin_a      (clk_a_s),
    .pin_b      (clk_b_s),
    .pin_sel    (gcfg[plc_pkg::GC_NET0_PIN]),
    .invert     (gcfg[plc_pkg::GC_NET0_INV]),
    .edge_pulse (net_pulse[0])
  ); // R5

  plc_clk_net u_net1 (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .pin_a      (clk_a_s),
    .pin_b      (clk_b_s),
    .pin_sel    (gcfg[plc_pkg::GC_NET1_PIN]),
    .invert     (gcfg[plc_pkg::GC_NET1_INV]),
    .edge_pulse (net_pulse[1])
  ); // R5

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign wr_go     = avs_write & ~avs_waitrequest;
  assign rd_go     = avs_read & avs_waitrequest;
  assign term_idx  = avs_address[11:4];
  assign term_word = avs_address[3:2];
  assign cfg_idx   = avs_address[5:2];
  assign in_term   = (avs_address < plc_pkg::TERM_END);
  assign in_cfg    = (avs_address >= plc_pkg::CFG_BASE) && (avs_address < plc_pkg::CFG_END);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (in_term) begin
      case (term_word)
        plc_pkg::TW_TRUE_LO: next_readdata = pt_true[term_idx][31:0];
        plc_pkg::TW_TRUE_HI: next_readdata = {12'h000, pt_true[term_idx][51:32]};
        plc_pkg::TW_COMP_LO: next_readdata = pt_comp[term_idx][31:0];
        default:             next_readdata = {12'h000, pt_comp[term_idx][51:32]};
      endcase
    end else if (in_cfg) begin
      next_readdata = mc_cfg[cfg_idx];
    end else if (avs_address == plc_pkg::GCFG_OFF) begin
      next_readdata = {28'h0000000, gcfg};
    end else if (avs_address == plc_pkg::STAT_OFF) begin
      next_readdata = {io_s, mc_q};
    end else if (avs_address == plc_pkg::PINS_OFF) begin
      next_readdata = {io_pin_oe, io_pin_out};
    end
  end

  // Captured at the take edge, so the data stand while waitrequest is low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  // Term masks are wide; reset clears them so every term reads low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < plc_pkg::NUM_TERM; k++) begin
        pt_true[k] <= '0;
        pt_comp[k] <= '0;
      end
    end else if (wr_go && in_term) begin
      case (term_word)
        plc_pkg::TW_TRUE_LO: pt_true[term_idx][31:0]  <= avs_writedata;
        plc_pkg::TW_TRUE_HI: pt_true[term_idx][51:32] <= avs_writedata[plc_pkg::TW_HI_W-1:0];
        plc_pkg::TW_COMP_LO: pt_comp[term_idx][31:0]  <= avs_writedata;
        default:             pt_comp[term_idx][51:32] <= avs_writedata[plc_pkg::TW_HI_W-1:0];
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
        mc_cfg[i] <= plc_pkg::MC_CFG_RESET;
      end
    end else if (wr_go && in_cfg) begin
      mc_cfg[cfg_idx] <= plc_pkg::norm_cfg(avs_writedata); // R2
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gcfg <= plc_pkg::GCFG_RESET;
    end else if (wr_go && (avs_address == plc_pkg::GCFG_OFF)) begin
      gcfg <= avs_writedata[3:0]; // R5
    end
  end

  // ----------------------------------------------------------------
  // Product-term array and expanders
  // ----------------------------------------------------------------
  assign lits = {mc_q, gia_s}; // R4 R12

  always_comb begin
    for (int k = 0; k < plc_pkg::NUM_TERM; k++) begin
      term_hit[k] = plc_pkg::pt_eval(pt_true[k], pt_comp[k], lits);
    end
  end

  // Shareable expanders are inverted terms any macrocell may pick up
  assign shx = ~term_hit[plc_pkg::SHX_BASE +: plc_pkg::NUM_MC]; // R11

  always_comb begin
    for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
      own_sum[i] = |term_hit[slot(i, 0) +: plc_pkg::PT_PER_MC]; // R10
    end
  end

  // Parallel expander borrows the five-term sum of the macrocell below
  assign own_chain = {own_sum, 1'b0};

  always_comb begin
    for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
      logic_sum[i] = own_sum[i]
                   | (|(mc_cfg[i][plc_pkg::MC_SHX_LSB +: plc_pkg::NUM_MC] & shx))
                   | (mc_cfg[i][plc_pkg::MC_PAR_EN] & own_chain[i]); // R11
    end
  end

  // ----------------------------------------------------------------
  // Speed/power: low power costs one extra cycle, same function
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      lp_dly <= 16'h0000;
    end else begin
      lp_dly <= logic_sum; // R13
    end
  end

  always_comb begin
    for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
      data_in[i] = mc_cfg[i][plc_pkg::MC_LOW_POWER] ? lp_dly[i] : logic_sum[i]; // R13
    end
  end

  // ----------------------------------------------------------------
  // Clock events, preset and clear
  // ----------------------------------------------------------------
  // One term per macrocell serves as gated-mode enable or as array clock
  always_comb begin
    for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
      clk_term[i] = term_hit[slot(i, plc_pkg::SLOT_CLOCK)];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aclk_d <= 16'h0000;
    end else begin
      aclk_d <= clk_term;
    end
  end

  // An array clock held high clocks once, on the cycle it is first seen
  always_comb begin
    for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
      case (plc_pkg::plc_clk_mode_e'(mc_cfg[i][plc_pkg::MC_MODE_LSB +: 2]))
        plc_pkg::PLC_CM_GLOBAL: clk_ev[i] = net_pulse[mc_cfg[i][plc_pkg::MC_NET_SEL]]; // R2
        plc_pkg::PLC_CM_GATED:  clk_ev[i] = net_pulse[mc_cfg[i][plc_pkg::MC_NET_SEL]]
                                          & clk_term[i]; // R3
        plc_pkg::PLC_CM_ARRAY:  clk_ev[i] = clk_term[i] & ~aclk_d[i]; // R4
        default:                clk_ev[i] = 1'b0;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
      do_preset[i] = term_hit[slot(i, plc_pkg::SLOT_PRESET)]; // R6
      do_clear[i]  = term_hit[slot(i, plc_pkg::SLOT_CLEAR)]
                   | (mc_cfg[i][plc_pkg::MC_GCLR_EN] & ~gclr_low_s); // R6 R7
    end
  end

  // ----------------------------------------------------------------
  // Macrocell flip-flops
  // ----------------------------------------------------------------
  // Preset and clear act on the cycle they are seen, without a clock event;
  // the sampling clock bounds how short a pulse can still be caught.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mc_q <= 16'h0000; // R8
    end else begin
      for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
        if (!mc_cfg[i][plc_pkg::MC_REGISTERED]) begin
          mc_q[i] <= data_in[i]; // R1
        end else if (do_clear[i]) begin
          mc_q[i] <= 1'b0; // R15
        end else if (do_preset[i]) begin
          mc_q[i] <= 1'b1; // R6
        end else if (clk_ev[i]) begin
          mc_q[i] <= mc_cfg[i][plc_pkg::MC_FAST_IN] ? io_s[i] : data_in[i]; // R9
        end
      end
    end
  end

  assign mc_out = mc_q;

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Open drain only ever pulls low, so several parts can share one line
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      io_pin_out <= 16'h0000;
      io_pin_oe  <= 16'h0000;
    end else begin
      for (int i = 0; i < plc_pkg::NUM_MC; i++) begin
        if (mc_cfg[i][plc_pkg::MC_OPEN_DRAIN]) begin
          io_pin_out[i] <= 1'b0; // R14
          io_pin_oe[i]  <= ~mc_q[i]; // R14
        end else begin
          io_pin_out[i] <= mc_q[i];
          io_pin_oe[i]  <= 1'b1;
        end
      end
    end
  end

endmodule : plc_macrocell_group

// ---- hdl/plc_pkg.sv ----
// Shared constants, types and helper functions for the macrocell group
package plc_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int NUM_MC      = 16;
  localparam int NUM_GIA     = 36;
  localparam int NUM_LIT     = NUM_GIA + NUM_MC;
  localparam int PT_PER_MC   = 5;
  localparam int SLOT_PER_MC = 8;
  localparam int SLOT_PRESET = 5;
  localparam int SLOT_CLEAR  = 6;
  localparam int SLOT_CLOCK  = 7;
  localparam int SHX_BASE    = NUM_MC * SLOT_PER_MC;
  localparam int NUM_TERM    = SHX_BASE + NUM_MC;
  localparam int SYNC_W      = NUM_GIA + NUM_MC + 3;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 13;
  localparam logic [12:0] TERM_END  = 13'h0900;
  localparam logic [12:0] CFG_BASE  = 13'h1000;
  localparam logic [12:0] CFG_END   = 13'h1040;
  localparam logic [12:0] GCFG_OFF  = 13'h1040;
  localparam logic [12:0] STAT_OFF  = 13'h1044;
  localparam logic [12:0] PINS_OFF  = 13'h1048;

  // Term word selects inside one term's four words
  localparam logic [1:0] TW_TRUE_LO = 2'h0;
  localparam logic [1:0] TW_TRUE_HI = 2'h1;
  localparam logic [1:0] TW_COMP_LO = 2'h2;
  localparam logic [1:0] TW_COMP_HI = 2'h3;
  localparam int         TW_HI_W    = NUM_LIT - 32;

  // Per-macrocell configuration fields
  localparam int MC_REGISTERED = 0;
  localparam int MC_MODE_LSB   = 1;
  localparam int MC_NET_SEL    = 3;
  localparam int MC_GCLR_EN    = 4;
  localparam int MC_FAST_IN    = 5;
  localparam int MC_LOW_POWER  = 6;
  localparam int MC_OPEN_DRAIN = 7;
  localparam int MC_PAR_EN     = 8;
  localparam int MC_SHX_LSB    = 16;
  localparam logic [31:0] MC_CFG_MASK  = 32'hffff_01ff;
  localparam logic [31:0] MC_CFG_RESET = 32'h0000_0000;

  // Global clock network fields
  localparam int GC_NET0_PIN = 0;
  localparam int GC_NET0_INV = 1;
  localparam int GC_NET1_PIN = 2;
  localparam int GC_NET1_INV = 3;
  localparam logic [3:0] GCFG_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLC_CM_GLOBAL = 2'b00,
    PLC_CM_GATED  = 2'b01,
    PLC_CM_ARRAY  = 2'b11
  } plc_clk_mode_e;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // An unprogrammed term (no literal used) reads low
  function automatic logic pt_eval(input logic [NUM_LIT-1:0] t_mask,
                                   input logic [NUM_LIT-1:0] c_mask,
                                   input logic [NUM_LIT-1:0] lits);
    pt_eval = (|(t_mask | c_mask)) && (&((~t_mask | lits) & (~c_mask | ~lits)));
  endfunction : pt_eval

  // The unused mode code is stored as the global mode
  function automatic logic [31:0] norm_cfg(input logic [31:0] wd);
    logic [31:0] v;
    v = wd & MC_CFG_MASK;
    if (v[MC_MODE_LSB +: 2] == 2'b10) begin
      v[MC_MODE_LSB +: 2] = PLC_CM_GLOBAL;
    end
    norm_cfg = v;
  endfunction : norm_cfg

endpackage : plc_pkg

// ---- hdl/plc_sync.sv ----
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module plc_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : plc_sync

// ---- verification/plc_group_props.sv ----
// Concurrent checks on the macrocell group ports
`timescale 1ns/1ps
module plc_group_props (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [12:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [15:0] io_pin_out,
  input wire logic [15:0] io_pin_oe,
  input wire logic [15:0] mc_out
);
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic gap;
  // Holes in the map must read as zero
  assign gap = (avs_address >= 13'h0900 && avs_address < 13'h1000) || avs_address >= 13'h104c;
  sequence bus_take;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (bus_take |=> bus_answer)
    else $error("bus answer not a one cycle pulse after request");
  idle_wait_a: assert property (avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest dropped with no request");
  wait_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("waitrequest fell without a request");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data changed outside an answer");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && gap |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // ----------------------------------------------------------------
  // Flip-flops and pins
  // ----------------------------------------------------------------
  reset_zero_a: assert property ($fell(sys_rst) |-> mc_out == 16'h0)
    else $error("flip-flops not zero after reset");
  drain_low_a: assert property ((io_pin_out & ~io_pin_oe) == 16'h0)
    else $error("released pin carries a high value");
  // Pins lag the flops by one edge, so compare with the past flop state
  drain_release_a: assert property (!$past(sys_rst) |-> (~io_pin_oe & ~$past(mc_out)) == 16'h0)
    else $error("pin released while its flop was low");
  pin_follow_a: assert property (!$past(sys_rst) |-> (io_pin_out & ~$past(mc_out)) == 16'h0)
    else $error("pin high while its flop was low");
endmodule : plc_group_props

// ---- verification/plc_macrocell_group_tb.sv ----
// Self-checking bench for the macrocell group
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module plc_macrocell_group_tb;
  logic        mclk, sys_rst, avs_read, avs_write, avs_waitrequest, pin_a, pin_b, clr_low;
  logic [12:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [35:0] gia;
  logic [15:0] io_pin_in, io_pin_out, io_pin_oe, mc_out, ext_low;
  int          miscompares, compares, i, lp;
  // Rows: gia[2:0] then expected macrocell 0 output
  logic [3:0]  rows [5] = '{4'b0000, 4'b0011, 4'b0110, 4'b1111, 4'b1001};
  // ----------------------------------------------------------------
  // Design and pins
  // ----------------------------------------------------------------
  plc_macrocell_group dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_clock_pin_a(pin_a), .global_clock_pin_b(pin_b), .global_clear_pin_low(clr_low),
    .global_interconnect_array(gia), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe), .mc_out(mc_out));
  plc_pin_model u_pins (.io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .ext_low(ext_low),
    .io_pin_in(io_pin_in));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic we, input logic [12:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= ~we;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [12:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  // A term with no literal in one polarity passes -1 for it
  task automatic term(input int k, input int tb, input int cb);
    logic [51:0] t, c;
    t = (tb < 0) ? 52'h0 : 52'h1 << tb;
    c = (cb < 0) ? 52'h0 : 52'h1 << cb;
    wr(13'(16 * k), t[31:0]);
    wr(13'(16 * k + 4), 32'(t[51:32]));
    wr(13'(16 * k + 8), c[31:0]);
    wr(13'(16 * k + 12), 32'(c[51:32]));
  endtask : term
  task automatic cfg(input int m, input logic [31:0] v);
    wr(13'h1000 + 13'(4 * m), v);
  endtask : cfg
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask : settle
  task automatic setg(input int b, input logic v);
    @(posedge mclk);
    gia[b] <= v;
    settle();
  endtask : setg
  // Clock pins stand still between pulses
  task automatic gpulse(input logic use_b);
    @(posedge mclk);
    if (use_b) pin_b <= 1'b1;
    else pin_a <= 1'b1;
    repeat (4) @(posedge mclk);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    settle();
  endtask : gpulse
  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #(25 * 20000);
    miscompares++;
    results();
  end
  initial begin
    sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 13'h0;
    avs_writedata = 32'h0; pin_a = 1'b0; pin_b = 1'b0; clr_low = 1'b1;
    gia = 36'h0; ext_low = 16'h0; miscompares = 0; compares = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    settle();
    `CHK("mc_out", 16'h0, mc_out)
    `CHK("pin_oe", 16'hffff, io_pin_oe)
    rd(13'h1000); `CHK("cfg0", 32'h0, q)
    rd(13'h1040); `CHK("gcfg", 32'h0, q)
    rd(13'h0a00); `CHK("hole", 32'h0, q)
    rd(13'h1ffc); `CHK("top", 32'h0, q)
    // Macrocell 0 combinatorial: (g0 & ~g1) | g2, then in low power
    term(0, 0, 1);
    term(1, 2, -1);
    for (lp = 0; lp < 2; lp++) begin
      cfg(0, lp ? 32'h40 : 32'h0);
      for (i = 0; i < 5; i++) begin
        @(posedge mclk);
        gia[2:0] <= rows[i][3:1];
        settle();
        `CHK("comb", rows[i][0], mc_out[0])
      end
    end
    // Shareable expander is inverted, parallel one borrows the neighbour's sum
    cfg(0, 32'h0001_0000);
    term(128, 6, -1);
    @(posedge mclk);
    gia <= 36'h0;
    settle();
    `CHK("shx", 1'b1, mc_out[0])
    setg(6, 1'b1); `CHK("shx", 1'b0, mc_out[0])
    cfg(1, 32'h100);
    setg(2, 1'b1); `CHK("par", 1'b1, mc_out[1])
    @(posedge mclk);
    gia <= 36'h0;
    // Macrocell 1 registered: D=g0, enable/clock=g3, preset=g4, clear=g5
    term(8, 0, -1); term(15, 3, -1); term(13, 4, -1); term(14, 5, -1);
    cfg(1, 32'h1);
    setg(0, 1'b1); `CHK("noclk", 1'b0, mc_out[1])
    gpulse(1'b0); `CHK("gclk", 1'b1, mc_out[1])
    wr(13'h1040, 32'h1);
    setg(0, 1'b0);
    gpulse(1'b0); `CHK("netb", 1'b1, mc_out[1])
    gpulse(1'b1); `CHK("netb", 1'b0, mc_out[1])
    wr(13'h1040, 32'h3);
    setg(0, 1'b1);
    @(posedge mclk); pin_b <= 1'b1; settle(); `CHK("inv", 1'b0, mc_out[1])
    @(posedge mclk); pin_b <= 1'b0; settle(); `CHK("inv", 1'b1, mc_out[1])
    cfg(1, 32'h9);
    setg(0, 1'b0);
    gpulse(1'b0); `CHK("net1", 1'b0, mc_out[1])
    wr(13'h1040, 32'h0);
    cfg(1, 32'h3);
    setg(0, 1'b1);
    gpulse(1'b0); `CHK("gated", 1'b0, mc_out[1])
    setg(3, 1'b1);
    gpulse(1'b0); `CHK("gated", 1'b1, mc_out[1])
    `CHK("pushpull", 1'b1, io_pin_out[1])
    setg(3, 1'b0);
    cfg(1, 32'h7);
    setg(0, 1'b0);
    gpulse(1'b0); `CHK("array", 1'b1, mc_out[1])
    setg(3, 1'b1); `CHK("array", 1'b0, mc_out[1])
    setg(4, 1'b1); `CHK("preset", 1'b1, mc_out[1])
    setg(5, 1'b1); `CHK("both", 1'b0, mc_out[1])
    setg(5, 1'b0); `CHK("preset", 1'b1, mc_out[1])
    setg(4, 1'b0);
    @(posedge mclk); clr_low <= 1'b0; settle(); `CHK("gclr_off", 1'b1, mc_out[1])
    @(posedge mclk); clr_low <= 1'b1;
    cfg(1, 32'h17);
    @(posedge mclk); clr_low <= 1'b0; settle(); `CHK("gclr", 1'b0, mc_out[1])
    @(posedge mclk); clr_low <= 1'b1;
    // Macrocell 2: open drain, fast pin input; its array path alone would load g7
    term(16, 7, -1); term(21, 8, -1);
    cfg(2, 32'ha1);
    setg(7, 1'b1);
    setg(8, 1'b1);
    `CHK("od_oe", 1'b0, io_pin_oe[2])
    `CHK("od_out", 1'b0, io_pin_out[2])
    setg(8, 1'b0);
    @(posedge mclk); ext_low[2] <= 1'b1; settle();
    gpulse(1'b0); `CHK("fast", 1'b0, mc_out[2])
    `CHK("od_oe", 1'b1, io_pin_oe[2])
    rd(13'h1004); `CHK("cfg1", 32'h17, q)
    cfg(3, 32'h0000_fe05);
    rd(13'h100c); `CHK("cfg3", 32'h1, q)
    // Reset again in mid-run
    @(posedge mclk); sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    settle();
    `CHK("mc_out", 16'h0, mc_out)
    rd(13'h1004); `CHK("cfg1", 32'h0, q)
    results();
  end
endmodule : plc_macrocell_group_tb
bind plc_macrocell_group plc_group_props u_props (.mclk(mclk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .io_pin_out(io_pin_out),
  .io_pin_oe(io_pin_oe), .mc_out(mc_out));

// ---- verification/plc_pin_model.sv ----
// Board side of the I/O pins: pull-up and another device on the wire
`timescale 1ns/1ps
module plc_pin_model (
  input  wire logic [15:0] io_pin_out,
  input  wire logic [15:0] io_pin_oe,
  input  wire logic [15:0] ext_low,
  output logic      [15:0] io_pin_in
);
  // Released pins go to the pull-up unless the other device pulls them low
  assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ~ext_low);
endmodule : plc_pin_model
